/* File: pdio_ext_model.sv */
// external i/o circuitry: output capture register and input drivers
// assumes strobe and data come registered from the port on ref_clk_i
`timescale 1ns/1ps
module pdio_ext_model
  import pdio_pkg::*;
#(
  parameter logic [15:0] DRIVE = 16'hA5C3
) (
  input  wire logic                   ref_clk_i,
  input  wire logic [PDIO_PROC_W-1:0] lines_i,
  input  wire logic                   strobe_i,
  output logic      [PDIO_PROC_W-1:0] captured_o,
  output logic      [PDIO_PROC_W-1:0] drive_o
);
  // steady drive; only bits the port leaves undriven reach its inputs
  assign drive_o = DRIVE;
  always_ff @(posedge ref_clk_i) begin
    if (strobe_i) begin
      captured_o <= lines_i;
    end
  end
endmodule : pdio_ext_model

/* File: pdio_pkg.sv */
// constants shared by the process digital i/o port and its synchroniser
// assumes one system clock and a synchronous active-high reset
package pdio_pkg;
  localparam int          PDIO_GEN_W      = 16;
  localparam int          PDIO_PROC_W     = 16;
  localparam int          PDIO_SYNC_W     = 2;
  localparam logic [15:0] PDIO_DATA_RST   = 16'h0000;
  localparam logic [1:0]  PDIO_SYNC_RST   = 2'h0;
  localparam logic        PDIO_BIT_RST    = 1'h0;
  // synchroniser stages start high so a pin high through reset is no edge
  localparam logic        PDIO_STAGE_RST  = 1'h1;
  // synchroniser stages before the edge-detect flop
  localparam int          PDIO_SYNC_STAGES = 2;
endpackage : pdio_pkg

/* File: pdio_port.sv */
// process digital i/o pin block: general in/out, process lines, strobes
// assumes all inputs are synchronous to ref_clk_i except the sample strobe and output enable
//
// Overview of operation
// RULE_01: each sync line is a pulse output or latch input, chosen per bit.
// RULE_02: every output stays undriven until configuration memory has loaded.
// RULE_03: sixteen general input pins map bit for bit into the input register.
// RULE_04: general inputs are not one consistent snapshot; software tolerates skew.
// RULE_05: general output pins follow their register; watchdog never gates them.
// RULE_06: sixteen process lines each act as input, output or bidirectional bit.
// RULE_07: outputs-valid strobe marks valid process output data for capture.
// RULE_08: process input data sampled on each rising edge of sample strobe.
// RULE_09: watchdog trigger output reports each process-data watchdog trigger.
// RULE_10: watchdog state output is low once expired, high otherwise.
// RULE_11: frame start output signals a frame beginning to pass through.
// RULE_12: frame end output signals a frame finishing passing through.
// RULE_13: output-enable input low clears process output data to zero.
// RULE_14: sample strobe and output enable are synchronised before use.
`timescale 1ns/1ps
module pdio_port
  import pdio_pkg::*;
#(
  parameter int GEN_W  = PDIO_GEN_W,
  parameter int PROC_W = PDIO_PROC_W,
  parameter int SYNC_W = PDIO_SYNC_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              config_loaded_i,
  input  wire logic [SYNC_W-1:0] sync_dir_out_i,
  input  wire logic [SYNC_W-1:0] sync_pulse_i,
  input  wire logic [SYNC_W-1:0] sync_pin_i,
  output logic      [SYNC_W-1:0] sync_pin_o,
  output logic      [SYNC_W-1:0] sync_pin_oe_o,
  output logic      [SYNC_W-1:0] latch_event_o,
  input  wire logic [GEN_W-1:0]  gen_in_pins_i,
  output logic      [GEN_W-1:0]  gen_in_reg_o,
  input  wire logic [GEN_W-1:0]  gen_out_reg_i,
  output logic      [GEN_W-1:0]  gen_out_pins_o,
  output logic      [GEN_W-1:0]  gen_out_pins_oe_o,
  input  wire logic [PROC_W-1:0] proc_dir_out_i,
  input  wire logic [PROC_W-1:0] proc_out_data_i,
  input  wire logic              proc_out_update_i,
  input  wire logic [PROC_W-1:0] proc_io_lines_i,
  output logic      [PROC_W-1:0] proc_io_lines_o,
  output logic      [PROC_W-1:0] proc_io_lines_oe_o,
  output logic      [PROC_W-1:0] proc_in_data_o,
  output logic                   proc_in_sampled_o,
  output logic                   outputs_valid_strobe_o,
  output logic                   outputs_valid_strobe_oe_o,
  input  wire logic              latch_in_i,
  input  wire logic              output_enable_in_i,
  input  wire logic              wd_trigger_i,
  input  wire logic              wd_expired_i,
  output logic                   sm_watchdog_trigger_o,
  output logic                   sm_watchdog_state_o,
  output logic                   sm_watchdog_oe_o,
  input  wire logic              frame_start_i,
  input  wire logic              frame_end_i,
  output logic                   frame_start_o,
  output logic                   frame_end_o,
  output logic                   frame_oe_o
);
  pdio_sync_if latch_sync ();
  pdio_sync_if oe_sync ();

  assign latch_sync.raw = latch_in_i;
  assign oe_sync.raw    = output_enable_in_i;

  pdio_sync u_latch_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .port      (latch_sync.sync_side)
  );

  pdio_sync u_oe_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .port      (oe_sync.sync_side)
  );

  logic              loaded;
  logic              next_loaded;
  logic [SYNC_W-1:0] next_sync_o;
  logic [SYNC_W-1:0] next_sync_oe;
  logic [SYNC_W-1:0] next_latch_ev;
  logic [SYNC_W-1:0] sync_in_q;
  logic [GEN_W-1:0]  next_gen_in;
  logic [GEN_W-1:0]  next_gen_out;
  logic [GEN_W-1:0]  next_gen_oe;
  logic [PROC_W-1:0] next_proc_o;
  logic [PROC_W-1:0] next_proc_oe;
  logic [PROC_W-1:0] next_proc_in;
  logic              next_sampled;
  logic              next_valid;
  logic              next_sm_watchdog_trigger;
  logic              next_sm_watchdog_state;
  logic              next_sof;
  logic              next_eof;
  logic              next_ctl_oe;

  always_comb begin
    next_loaded   = config_loaded_i;
    // sync lines: drive when configured as output, else catch latch edges
    next_sync_oe  = loaded ? sync_dir_out_i : PDIO_SYNC_RST; // RULE_01 RULE_02
    next_sync_o   = sync_pulse_i & sync_dir_out_i; // RULE_01
    next_latch_ev = sync_pin_i & ~sync_in_q & ~sync_dir_out_i; // RULE_01
    // no snapshot: each bit is simply the pin one cycle late
    next_gen_in   = gen_in_pins_i; // RULE_03 RULE_04
    next_gen_out  = gen_out_reg_i; // RULE_05
    next_gen_oe   = loaded ? {GEN_W{1'b1}} : {GEN_W{1'b0}}; // RULE_02
    next_proc_oe  = loaded ? proc_dir_out_i : {PROC_W{1'b0}}; // RULE_06
    next_proc_o   = proc_io_lines_o;
    next_valid    = 1'b0;
    if (!oe_sync.level) begin
      next_proc_o = {PROC_W{1'b0}}; // RULE_13
    end else if (proc_out_update_i) begin
      next_proc_o = proc_out_data_i; // RULE_06
      next_valid  = 1'b1; // RULE_07
    end
    next_proc_in  = proc_in_data_o;
    next_sampled  = latch_sync.rise; // RULE_08
    if (latch_sync.rise) begin
      next_proc_in = proc_io_lines_i; // RULE_08
    end
    next_sm_watchdog_trigger  = wd_trigger_i; // RULE_09
    next_sm_watchdog_state = ~wd_expired_i; // RULE_10
    next_sof      = frame_start_i; // RULE_11
    next_eof      = frame_end_i; // RULE_12
    next_ctl_oe   = loaded; // RULE_02
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      loaded                    <= PDIO_BIT_RST;
      sync_pin_o                <= PDIO_SYNC_RST;
      sync_pin_oe_o             <= PDIO_SYNC_RST;
      latch_event_o             <= PDIO_SYNC_RST;
      sync_in_q                 <= PDIO_SYNC_RST;
      gen_in_reg_o              <= PDIO_DATA_RST;
      gen_out_pins_o            <= PDIO_DATA_RST;
      gen_out_pins_oe_o         <= PDIO_DATA_RST;
      proc_io_lines_o           <= PDIO_DATA_RST;
      proc_io_lines_oe_o        <= PDIO_DATA_RST;
      proc_in_data_o            <= PDIO_DATA_RST;
      proc_in_sampled_o         <= PDIO_BIT_RST;
      outputs_valid_strobe_o    <= PDIO_BIT_RST;
      outputs_valid_strobe_oe_o <= PDIO_BIT_RST;
      sm_watchdog_trigger_o     <= PDIO_BIT_RST;
      sm_watchdog_state_o       <= PDIO_BIT_RST;
      sm_watchdog_oe_o          <= PDIO_BIT_RST;
      frame_start_o             <= PDIO_BIT_RST;
      frame_end_o               <= PDIO_BIT_RST;
      frame_oe_o                <= PDIO_BIT_RST;
    end else begin
      loaded                    <= next_loaded;
      sync_pin_o                <= next_sync_o;
      sync_pin_oe_o             <= next_sync_oe;
      latch_event_o             <= next_latch_ev;
      sync_in_q                 <= sync_pin_i;
      gen_in_reg_o              <= next_gen_in;
      gen_out_pins_o            <= next_gen_out;
      gen_out_pins_oe_o         <= next_gen_oe;
      proc_io_lines_o           <= next_proc_o;
      proc_io_lines_oe_o        <= next_proc_oe;
      proc_in_data_o            <= next_proc_in;
      proc_in_sampled_o         <= next_sampled;
      outputs_valid_strobe_o    <= next_valid;
      outputs_valid_strobe_oe_o <= next_ctl_oe;
      sm_watchdog_trigger_o     <= next_sm_watchdog_trigger;
      sm_watchdog_state_o       <= next_sm_watchdog_state;
      sm_watchdog_oe_o          <= next_ctl_oe;
      frame_start_o             <= next_sof;
      frame_end_o               <= next_eof;
      frame_oe_o                <= next_ctl_oe;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence load_low_s;
    !config_loaded_i ##1 !loaded;
  endsequence

  hiz_before_load_a: assert property ( // RULE_02
    load_low_s |=> (sync_pin_oe_o == '0) && (gen_out_pins_oe_o == '0)
      && (proc_io_lines_oe_o == '0) && !outputs_valid_strobe_oe_o
      && !sm_watchdog_oe_o && !frame_oe_o)
    else $error("output driven before configuration load");

  sync_dir_a: assert property ( // RULE_01
    1'b1 |=> sync_pin_oe_o == ($past(sync_dir_out_i) & {SYNC_W{$past(loaded)}}))
    else $error("sync line direction mismatch");

  gen_in_map_a: assert property ( // RULE_03
    1'b1 |=> gen_in_reg_o == $past(gen_in_pins_i))
    else $error("general input register not following pins");

  gen_out_follow_a: assert property ( // RULE_05
    wd_expired_i |=> gen_out_pins_o == $past(gen_out_reg_i))
    else $error("general outputs gated by watchdog");

  proc_clear_a: assert property ( // RULE_13
    !oe_sync.level |=> (proc_io_lines_o == '0) && !outputs_valid_strobe_o)
    else $error("process outputs not cleared while disabled");

  sequence out_update_s;
    oe_sync.level && proc_out_update_i;
  endsequence

  out_valid_a: assert property ( // RULE_07
    out_update_s |=> outputs_valid_strobe_o
      && proc_io_lines_o == $past(proc_out_data_i))
    else $error("outputs-valid strobe without matching data");

  sequence latch_rise_s;
    !latch_in_i ##1 latch_in_i;
  endsequence

  latch_sample_a: assert property ( // RULE_08
    latch_rise_s |-> ##3 (proc_in_sampled_o
      && proc_in_data_o == $past(proc_io_lines_i)))
    else $error("process input not sampled on strobe edge");

  wd_out_a: assert property ( // RULE_09 RULE_10
    1'b1 |=> sm_watchdog_state_o == !$past(wd_expired_i)
      && sm_watchdog_trigger_o == $past(wd_trigger_i))
    else $error("watchdog outputs wrong");

  frame_out_a: assert property ( // RULE_11 RULE_12
    frame_start_i || frame_end_i |=> frame_start_o == $past(frame_start_i)
      && frame_end_o == $past(frame_end_i))
    else $error("frame indication wrong");
endmodule : pdio_port

/* File: pdio_port_tb_top.sv */
// self-checking bench for the process digital i/o port
// assumes pdio_ext_model stands on the process lines
`timescale 1ns/1ps
module pdio_port_tb_top
  import pdio_pkg::*;
;
  logic        ref_clk_i = 0, rst_i = 1, cfg = 0, upd = 0, latch = 0;
  logic        oe_in = 1, wdt = 0, wde = 0, fs = 0, fe = 0;
  logic [1:0]  sdir = 0, spulse = 0, sext = 0, spin_o, spin_oe, levt;
  logic [15:0] gin = 0, gout = 0, pdir = 0, pdata = 0;
  logic [15:0] gin_reg, gen_out_pins, gpo_oe, plo, ploe, pin_data, cap, ext;
  logic        psamp, ovs, ovs_oe, wtrig, wstate, woe, fso, feo, foe;
  int          num_errors = 0, tests_run = 0;
  // each pin resolves to whoever drives it
  wire  [15:0] pins  = (ploe & plo) | (~ploe & ext);
  wire  [1:0]  spins = (spin_oe & spin_o) | (~spin_oe & sext);

  always #2 ref_clk_i = ~ref_clk_i;

  pdio_port u_pdio_port (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .config_loaded_i(cfg),
    .sync_dir_out_i(sdir), .sync_pulse_i(spulse), .sync_pin_i(spins),
    .sync_pin_o(spin_o), .sync_pin_oe_o(spin_oe), .latch_event_o(levt),
    .gen_in_pins_i(gin), .gen_in_reg_o(gin_reg), .gen_out_reg_i(gout),
    .gen_out_pins_o(gen_out_pins), .gen_out_pins_oe_o(gpo_oe),
    .proc_dir_out_i(pdir), .proc_out_data_i(pdata),
    .proc_out_update_i(upd), .proc_io_lines_i(pins),
    .proc_io_lines_o(plo), .proc_io_lines_oe_o(ploe),
    .proc_in_data_o(pin_data), .proc_in_sampled_o(psamp),
    .outputs_valid_strobe_o(ovs), .outputs_valid_strobe_oe_o(ovs_oe),
    .latch_in_i(latch), .output_enable_in_i(oe_in), .wd_trigger_i(wdt),
    .wd_expired_i(wde), .sm_watchdog_trigger_o(wtrig),
    .sm_watchdog_state_o(wstate), .sm_watchdog_oe_o(woe),
    .frame_start_i(fs), .frame_end_i(fe), .frame_start_o(fso),
    .frame_end_o(feo), .frame_oe_o(foe));

  pdio_ext_model u_pdio_ext_model (
    .ref_clk_i(ref_clk_i), .lines_i(plo), .strobe_i(ovs),
    .captured_o(cap), .drive_o(ext));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task conclude;
    $display("tests %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task t_load;
    @(negedge ref_clk_i);
    chk(gpo_oe | ploe, 16'h0000);
    chk({spin_oe, ovs_oe, woe, foe}, 16'h0000);
    @(posedge ref_clk_i);
    cfg <= 1;
    pdir <= 16'h00FF;
    sdir <= 2'h1;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(gpo_oe, 16'hFFFF);
    chk(ploe, 16'h00FF);
    chk({spin_oe, ovs_oe, woe, foe}, 16'h000F);
    $display("test load done");
  endtask : t_load

  task t_gen;
    @(posedge ref_clk_i);
    gin <= 16'h1234;
    gout <= 16'hBEEF;
    wde <= 1;
    @(posedge ref_clk_i);
    wde <= 0;
    @(negedge ref_clk_i);
    chk(gin_reg, 16'h1234);
    chk(gen_out_pins, 16'hBEEF);
    chk(wstate, 16'h0000);
    @(negedge ref_clk_i);
    chk(wstate, 16'h0001);
    $display("test gen done");
  endtask : t_gen

  task t_wdf;
    @(posedge ref_clk_i);
    wdt <= 1;
    fs <= 1;
    @(posedge ref_clk_i);
    wdt <= 0;
    fs <= 0;
    fe <= 1;
    @(negedge ref_clk_i);
    chk({wtrig, fso, feo}, 16'h0006);
    @(posedge ref_clk_i);
    fe <= 0;
    @(negedge ref_clk_i);
    chk({wtrig, fso, feo}, 16'h0001);
    $display("test watchdog frame done");
  endtask : t_wdf

  task t_proc;
    @(posedge ref_clk_i);
    upd <= 1;
    pdata <= 16'h1111;
    @(posedge ref_clk_i);
    pdata <= 16'h2C3A;
    @(negedge ref_clk_i);
    chk(plo, 16'h1111);
    chk(ovs, 16'h0001);
    @(posedge ref_clk_i);
    upd <= 0;
    @(negedge ref_clk_i);
    chk(plo, 16'h2C3A);
    chk(ovs, 16'h0001);
    @(negedge ref_clk_i);
    chk(ovs, 16'h0000);
    chk(cap, 16'h2C3A);
    @(posedge ref_clk_i);
    oe_in <= 0;
    repeat (3) @(posedge ref_clk_i);
    upd <= 1;
    pdata <= 16'hFFFF;
    @(posedge ref_clk_i);
    upd <= 0;
    @(negedge ref_clk_i);
    chk(plo, 16'h0000);
    chk(ovs, 16'h0000);
    @(posedge ref_clk_i);
    oe_in <= 1;
    repeat (3) @(posedge ref_clk_i);
    $display("test process out done");
  endtask : t_proc

  task t_latch;
    @(posedge ref_clk_i);
    latch <= 1;
    repeat (2) @(posedge ref_clk_i);
    latch <= 0;
    @(negedge ref_clk_i);
    chk(psamp, 16'h0000);
    @(negedge ref_clk_i);
    chk(pin_data, 16'hA500);
    chk(psamp, 16'h0001);
    repeat (2) @(posedge ref_clk_i);
    $display("test latch done");
  endtask : t_latch

  task t_sync;
    logic found;
    found = 0;
    @(posedge ref_clk_i);
    spulse <= 2'h3;
    @(posedge ref_clk_i);
    sext <= 2'h2;
    @(negedge ref_clk_i);
    chk(spin_o, 16'h0001);
    repeat (5) begin
      @(negedge ref_clk_i);
      if (levt === 2'h2) found = 1;
    end
    chk(found, 16'h0001);
    $display("test sync done");
  endtask : t_sync

  initial begin
    #4000;
    num_errors++;
    conclude;
  end

  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 0;
    t_load;
    t_gen;
    t_wdf;
    t_proc;
    t_latch;
    t_sync;
    conclude;
  end
endmodule : pdio_port_tb_top

/* File: pdio_sync.sv */
// two-flop synchroniser with rising-edge detect
// assumes ref_clk_i is the system clock and rst_i is synchronous
`timescale 1ns/1ps
module pdio_sync
  import pdio_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  pdio_sync_if.sync_side  port
);
  logic s1;
  logic s2;
  logic s3;
  logic next_s1;
  logic next_s2;
  logic next_s3;

  always_comb begin
    next_s1 = port.raw;
    next_s2 = s1; // first stage seen by nothing else
    next_s3 = s2;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      // a zero here would flag a false rise for an idle-high pin
      s1 <= PDIO_STAGE_RST;
      s2 <= PDIO_STAGE_RST;
      s3 <= PDIO_STAGE_RST;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  assign port.level = s2; // RULE_14
  assign port.rise  = s2 & ~s3; // RULE_14

  sync_edge_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_14
    port.rise |-> $past(port.raw, 2) && !$past(port.raw, 3))
    else $error("edge flagged without synchronised raw rise");
endmodule : pdio_sync

/* File: pdio_sync_if.sv */
// carries one asynchronous-style input and its synchronised level and edge
// assumes the raw pin is driven by the top module
`timescale 1ns/1ps
interface pdio_sync_if;
  logic raw;
  logic level;
  logic rise;
  modport sync_side (input raw, output level, output rise);
  modport user_side (output raw, input level, input rise);
endinterface : pdio_sync_if
